//--- shared/pedc_pkg.sv
// Package: register map, field positions, reset values and types of the event/diag/control bank
package pedc_pkg;
	localparam logic [4:0] REG_EVENT = 5'h1b;
	localparam logic [4:0] REG_CABLE = 5'h1d;
	localparam logic [4:0] REG_CTRL1 = 5'h1e;
	localparam logic [4:0] REG_CTRL2 = 5'h1f;
	localparam int EN_LSB = 8;
	localparam int TEST_RUN_BIT = 15;
	localparam int RESULT_LSB = 13;
	localparam int FAULT_LSB = 0;
	localparam int LED_LSB = 14;
	localparam int POL_BIT = 13;
	localparam int FEF_BIT = 12;
	localparam int XOVER_BIT = 11;
	localparam int LOOP_BIT = 7;
	localparam int INT_LVL_BIT = 9;
	localparam logic [7:0] RST_EN = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [1:0] RST_RESULT = 2'h0;
	localparam logic [8:0] RST_FAULT = 9'h000;
	localparam logic [1:0] RST_LED = 2'h0;
	localparam logic RST_LOOP = 1'b0;
	localparam logic RST_INT_LVL = 1'b0;
	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [3:0] HDR_LAST = 4'hc;
	localparam logic [3:0] DATA_LAST = 4'hf;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR = 2'b01,
		ST_TA = 2'b11,
		ST_DATA = 2'b10
	} pedc_state_t;
	// Event bits: 7 jabber, 6 rx error, 5 page, 4 par-det fault, 3 lp ack, 2 link down, 1 remote fault, 0 link up
	typedef struct packed {
		logic done;
		logic [1:0] result;
		logic [8:0] fault_count;
	} pedc_cable_t;
	typedef struct packed {
		logic polarity_rev;
		logic far_end_fault;
		logic xover_state;
	} pedc_line_t;
endpackage

//--- rtl/pedc_regs.sv
// Event, cable diagnostic and control registers behind the serial management port
// Summary of operation
// - Bit 13 enables page-received interrupt; bit 5 flags page received, clears on read.
// - Bit 12 enables parallel-detect-fault interrupt; bit 4 flags it, clears on read.
// - Bit 11 enables partner-acknowledge interrupt; bit 3 flags it, clears on read.
// - Bit 10 enables link-down interrupt; bit 2 flags link down, clears on read.
// - Bit 9 enables remote-fault interrupt; bit 1 flags remote fault, clears on read.
// - Bit 8 enables link-up interrupt; bit 0 flags link up, clears on read.
// - Bit 6 flags receive error, read-only, clears on read, resets to zero.
// - Bit 15 is read-write jabber interrupt enable, reset zero.
// - Bit 14 is read-write receive-error interrupt enable, reset zero.
// - Second control bit 9 picks interrupt polarity; one high, zero low.
// - Writing one to bit 15 starts cable test; cleared when test finishes.
// - Two-bit result: normal, open, short, failed; resets to normal.
// - Nine-bit read-only fault distance count, about 0.4 m each, resets zero.
// - LED mode field selects speed or activity on second light.
// - Read-only bit 13 reports reversed receive polarity.
// - Read-only bit 12 reports far-end fault, fiber only, resets zero.
// - Read-write bit 7 selects remote analogue loopback, reset zero.
`timescale 1ns/1ps
module pedc_regs #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_mdc,
	input wire logic i_mdio_in,
	output logic o_mdio_out,
	output logic o_mdio_oe,
	input wire logic [7:0] i_events,
	input wire pedc_pkg::pedc_cable_t i_cable,
	input wire pedc_pkg::pedc_line_t i_line,
	output logic o_int,
	output logic o_cable_test_run,
	output logic [1:0] o_led_mode,
	output logic o_remote_loopback
);
	pedc_pkg::pedc_state_t state_reg, state_next;
	logic mdc_prev_reg, mdc_prev_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [12:0] hdr_reg, hdr_next;
	logic [15:0] shift_reg, shift_next;
	logic hit_reg, hit_next;
	logic rd_reg, rd_next;
	logic mdio_out_reg, mdio_out_next;
	logic mdio_oe_reg, mdio_oe_next;
	logic [7:0] en_reg, en_next;
	logic [7:0] flag_reg, flag_next;
	logic test_run_reg, test_run_next;
	logic [1:0] result_reg, result_next;
	logic [8:0] fault_reg, fault_next;
	logic [1:0] led_reg, led_next;
	logic loop_reg, loop_next;
	logic int_lvl_reg, int_lvl_next;
	logic int_reg, int_next;
	logic rise;
	logic rd_clr;
	logic commit;
	logic [15:0] wdata;
	logic [4:0] reg_addr;
	logic [15:0] rdata;
	logic any_evt;

	// Inputs are synchronous to i_clk, so the bus clock edge is found directly
	assign rise = i_mdc & ~mdc_prev_reg;
	assign reg_addr = hdr_reg[4:0];
	assign wdata = {shift_reg[14:0], i_mdio_in};
	assign rd_clr = rise && state_reg == pedc_pkg::ST_HDR && cnt_reg[3:0] == pedc_pkg::HDR_LAST
		&& hdr_next[12] && hdr_next[11:10] == pedc_pkg::OP_READ && hdr_next[9:5] == PHY_ADDR
		&& hdr_next[4:0] == pedc_pkg::REG_EVENT;
	assign commit = rise && state_reg == pedc_pkg::ST_DATA && cnt_reg[3:0] == pedc_pkg::DATA_LAST
		&& hit_reg && !rd_reg;
	assign any_evt = |(flag_reg & en_reg);

	// Read word for the address just decoded; unmapped addresses read zero
	always_comb begin
		rdata = 16'h0000;
		unique case (hdr_next[4:0])
			pedc_pkg::REG_EVENT: begin
				rdata = {en_reg, flag_reg};
			end
			pedc_pkg::REG_CABLE: begin
				rdata[pedc_pkg::TEST_RUN_BIT] = test_run_reg;
				rdata[pedc_pkg::RESULT_LSB +: 2] = result_reg;
				rdata[pedc_pkg::FAULT_LSB +: 9] = fault_reg;
			end
			pedc_pkg::REG_CTRL1: begin
				rdata[pedc_pkg::LED_LSB +: 2] = led_reg;
				rdata[pedc_pkg::POL_BIT] = i_line.polarity_rev;
				rdata[pedc_pkg::FEF_BIT] = i_line.far_end_fault;
				rdata[pedc_pkg::XOVER_BIT] = i_line.xover_state;
				rdata[pedc_pkg::LOOP_BIT] = loop_reg;
			end
			pedc_pkg::REG_CTRL2: begin
				rdata[pedc_pkg::INT_LVL_BIT] = int_lvl_reg;
			end
			default: begin
				rdata = 16'h0000;
			end
		endcase
	end

	// Management frame engine
	always_comb begin
		state_next = state_reg;
		mdc_prev_next = i_mdc;
		cnt_next = cnt_reg;
		// Header shifts only in its own phase, so the address holds until a write commits
		hdr_next = hdr_reg;
		shift_next = shift_reg;
		hit_next = hit_reg;
		rd_next = rd_reg;
		mdio_out_next = mdio_out_reg;
		mdio_oe_next = mdio_oe_reg;
		if (rise) begin
			unique case (state_reg)
				pedc_pkg::ST_IDLE: begin
					if (i_mdio_in) begin
						if (cnt_reg < pedc_pkg::PREAMBLE_LEN) begin
							cnt_next = cnt_reg + 6'h01;
						end
					end else if (cnt_reg >= pedc_pkg::PREAMBLE_LEN) begin
						state_next = pedc_pkg::ST_HDR;
						cnt_next = 6'h00;
					end else begin
						cnt_next = 6'h00;
					end
				end
				pedc_pkg::ST_HDR: begin
					hdr_next = {hdr_reg[11:0], i_mdio_in};
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg[3:0] == pedc_pkg::HDR_LAST) begin
						state_next = pedc_pkg::ST_TA;
						cnt_next = 6'h00;
						rd_next = hdr_next[11:10] == pedc_pkg::OP_READ;
						hit_next = hdr_next[12] && hdr_next[9:5] == PHY_ADDR
							&& (hdr_next[11:10] == pedc_pkg::OP_READ || hdr_next[11:10] == pedc_pkg::OP_WRITE);
						shift_next = rdata;
					end
				end
				pedc_pkg::ST_TA: begin
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == 6'h00) begin
						// Second turnaround bit is driven low by the device on reads
						mdio_oe_next = hit_reg && rd_reg;
						mdio_out_next = 1'b0;
					end else begin
						state_next = pedc_pkg::ST_DATA;
						cnt_next = 6'h00;
						mdio_out_next = shift_reg[15];
					end
				end
				pedc_pkg::ST_DATA: begin
					cnt_next = cnt_reg + 6'h01;
					shift_next = rd_reg ? {shift_reg[14:0], 1'b0} : wdata;
					mdio_out_next = shift_reg[14];
					if (cnt_reg[3:0] == pedc_pkg::DATA_LAST) begin
						state_next = pedc_pkg::ST_IDLE;
						cnt_next = 6'h00;
						mdio_oe_next = 1'b0;
						mdio_out_next = 1'b0;
					end
				end
			endcase
		end
	end

	// Register bank; new events win over the clear caused by a read
	always_comb begin
		en_next = en_reg;
		test_run_next = test_run_reg;
		result_next = result_reg;
		fault_next = fault_reg;
		led_next = led_reg;
		loop_next = loop_reg;
		int_lvl_next = int_lvl_reg;
		flag_next = (rd_clr ? 8'h00 : flag_reg) | i_events;
		if (test_run_reg && i_cable.done) begin
			test_run_next = 1'b0;
			result_next = i_cable.result;
			fault_next = i_cable.fault_count;
		end
		if (commit) begin
			unique case (reg_addr)
				pedc_pkg::REG_EVENT: begin
					en_next = wdata[pedc_pkg::EN_LSB +: 8];
				end
				pedc_pkg::REG_CABLE: begin
					// A start written in the completion cycle wins and begins a new test
					if (wdata[pedc_pkg::TEST_RUN_BIT]) begin
						test_run_next = 1'b1;
					end
				end
				pedc_pkg::REG_CTRL1: begin
					led_next = wdata[pedc_pkg::LED_LSB +: 2];
					loop_next = wdata[pedc_pkg::LOOP_BIT];
				end
				pedc_pkg::REG_CTRL2: begin
					int_lvl_next = wdata[pedc_pkg::INT_LVL_BIT];
				end
				default: begin
					en_next = en_reg;
				end
			endcase
		end
		int_next = int_lvl_reg ? any_evt : ~any_evt;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= pedc_pkg::ST_IDLE;
			mdc_prev_reg <= 1'b0;
			cnt_reg <= 6'h00;
			hdr_reg <= 13'h0000;
			shift_reg <= 16'h0000;
			hit_reg <= 1'b0;
			rd_reg <= 1'b0;
			mdio_out_reg <= 1'b0;
			mdio_oe_reg <= 1'b0;
			en_reg <= pedc_pkg::RST_EN;
			flag_reg <= pedc_pkg::RST_FLAGS;
			test_run_reg <= 1'b0;
			result_reg <= pedc_pkg::RST_RESULT;
			fault_reg <= pedc_pkg::RST_FAULT;
			led_reg <= pedc_pkg::RST_LED;
			loop_reg <= pedc_pkg::RST_LOOP;
			int_lvl_reg <= pedc_pkg::RST_INT_LVL;
			int_reg <= 1'b1;
		end else if (i_ce) begin
			state_reg <= state_next;
			mdc_prev_reg <= mdc_prev_next;
			cnt_reg <= cnt_next;
			hdr_reg <= hdr_next;
			shift_reg <= shift_next;
			hit_reg <= hit_next;
			rd_reg <= rd_next;
			mdio_out_reg <= mdio_out_next;
			mdio_oe_reg <= mdio_oe_next;
			en_reg <= en_next;
			flag_reg <= flag_next;
			test_run_reg <= test_run_next;
			result_reg <= result_next;
			fault_reg <= fault_next;
			led_reg <= led_next;
			loop_reg <= loop_next;
			int_lvl_reg <= int_lvl_next;
			int_reg <= int_next;
		end
	end

	assign o_mdio_out = mdio_out_reg;
	assign o_mdio_oe = mdio_oe_reg;
	assign o_int = int_reg;
	assign o_cable_test_run = test_run_reg;
	assign o_led_mode = led_reg;
	assign o_remote_loopback = loop_reg;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence rd_turn_s;
		i_ce && rise && state_reg == pedc_pkg::ST_TA && cnt_reg == 6'h00 && hit_reg && rd_reg;
	endsequence
	sequence frame_end_s;
		i_ce && rise && state_reg == pedc_pkg::ST_DATA && cnt_reg[3:0] == pedc_pkg::DATA_LAST;
	endsequence

	evt_sticky_a: assert property (i_ce && |i_events |=> (flag_reg & $past(i_events)) == $past(i_events))
		else $error("event flag not set");
	read_clear_a: assert property (i_ce && rd_clr |=> flag_reg == $past(i_events))
		else $error("flags not cleared by read");
	flag_hold_a: assert property (i_ce && !rd_clr && i_events == 8'h00 |=> flag_reg == $past(flag_reg))
		else $error("flag changed without cause");
	int_level_a: assert property (i_ce ##1 i_ce && $stable(flag_reg) && $stable(en_reg) && $stable(int_lvl_reg)
		|-> o_int == (int_lvl_reg ? |(flag_reg & en_reg) : !(|(flag_reg & en_reg))))
		else $error("interrupt pin level wrong");
	test_done_a: assert property (i_ce && test_run_reg && i_cable.done && !commit
		|=> !test_run_reg && result_reg == $past(i_cable.result) && fault_reg == $past(i_cable.fault_count))
		else $error("cable test did not complete");
	test_hold_a: assert property (test_run_reg && !i_cable.done |=> test_run_reg)
		else $error("cable test ended early");
	ta_drive_a: assert property (rd_turn_s |=> o_mdio_oe && !o_mdio_out)
		else $error("turnaround not driven low");
	oe_release_a: assert property (frame_end_s |=> !o_mdio_oe ##1 !o_mdio_oe)
		else $error("data line not released");
	ctrl_write_a: assert property (i_ce && commit && reg_addr == pedc_pkg::REG_CTRL1
		|=> o_led_mode == $past(wdata[15:14]) && o_remote_loopback == $past(wdata[7]))
		else $error("control write lost");
	en_write_a: assert property (i_ce && commit && reg_addr == pedc_pkg::REG_EVENT |=> en_reg == $past(wdata[15:8]))
		else $error("enable write lost");
	en_hold_a: assert property (!commit |=> en_reg == $past(en_reg))
		else $error("enable changed without write");
endmodule

//--- bench/pedc_host.sv
// Management bus master model that frames reads and writes for the register bank
`timescale 1ns/1ps
module pedc_host (
	input wire logic i_clk,
	input wire logic i_mdio,
	output logic o_mdc,
	output logic o_mdio,
	output logic o_mdio_oe,
	output logic o_rd_valid,
	output logic [15:0] o_rd_data
);
	int slow = 0;
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_mdio_oe = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_data = 16'h0000;
	end
	// The line is sampled late in the low half, so a slow device still meets it
	task automatic bit_cyc(input logic b, input logic oe, output logic s);
		@(posedge i_clk);
		o_mdio <= b;
		o_mdio_oe <= oe;
		o_mdc <= 1'b0;
		repeat (3 + slow) @(posedge i_clk);
		s = i_mdio;
		o_mdc <= 1'b1;
		repeat (3 + slow) @(posedge i_clk);
	endtask
	// Each frame carries its own full preamble; the line is released for a read turnaround
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
		logic [63:0] f;
		logic [15:0] d;
		logic s;
		int i;
		f = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
		d = 16'h0000;
		for (i = 63; i >= 0; i--) begin
			bit_cyc(f[i], (i > 17) || (op == pedc_pkg::OP_WRITE), s);
			if (i < 16) d = {d[14:0], s};
		end
		@(posedge i_clk);
		o_mdc <= 1'b0;
		o_mdio_oe <= 1'b0;
		o_rd_valid <= (op == pedc_pkg::OP_READ);
		o_rd_data <= d;
		@(posedge i_clk);
		o_rd_valid <= 1'b0;
	endtask
endmodule

//--- bench/phy_event_diag_ctrl_regs_test.sv
// Self-checking bench for the event, cable test and control register bank
`timescale 1ns/1ps
module phy_event_diag_ctrl_regs_test;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] ev = 8'h00;
	pedc_pkg::pedc_cable_t cab = '0;
	pedc_pkg::pedc_line_t lin = '0;
	logic mdc, h_out, h_oe, d_out, d_oe, rv, mdio, irq, run, loop;
	logic [1:0] led;
	logic [15:0] rdat;
	logic [15:0] exp_q[$];
	int fail_count = 0;
	int n_tests = 0;
	int seed = 21340;
	int k;
	logic [7:0] en, e;
	logic [8:0] cnt, pc;
	logic [1:0] pr;
	logic [2:0] ln;
	always #2.5 i_clk = ~i_clk;
	// Pulled-up line: nobody driving reads as one
	assign mdio = d_oe ? d_out : (h_oe ? h_out : 1'b1);
	pedc_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_mdc(mdc), .i_mdio_in(mdio),
		.o_mdio_out(d_out), .o_mdio_oe(d_oe), .i_events(ev), .i_cable(cab), .i_line(lin), .o_int(irq),
		.o_cable_test_run(run), .o_led_mode(led), .o_remote_loopback(loop));
	pedc_host u_host (.i_clk(i_clk), .i_mdio(mdio), .o_mdc(mdc), .o_mdio(h_out), .o_mdio_oe(h_oe),
		.o_rd_valid(rv), .o_rd_data(rdat));
	task automatic check(input logic [15:0] got, input logic [15:0] x);
		n_tests++;
		if (got !== x) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, x);
		end
	endtask
	task automatic results();
		$display("Counts: %0d compares, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] x);
		exp_q.push_back(x);
		u_host.frame(pedc_pkg::OP_READ, phy, ra, 16'h0000);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] w);
		u_host.frame(pedc_pkg::OP_WRITE, 5'h01, ra, w);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge i_clk);
		ev <= v;
		@(posedge i_clk);
		ev <= 8'h00;
		repeat (3) @(posedge i_clk);
	endtask
	always @(posedge i_clk) begin
		if (rv) begin
			if (exp_q.size() > 0) check(rdat, exp_q.pop_front());
			else check(rdat, 16'hxxxx);
		end
	end
	initial begin
		#250000;
		fail_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		results();
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		check({15'h0, irq}, 16'h0001);
		check({12'h0, run, led, loop}, 16'h0000);
		rd(5'h01, pedc_pkg::REG_EVENT, 16'h0000);
		rd(5'h01, pedc_pkg::REG_CABLE, 16'h0000);
		$display("test reset done");
		// Flag bits are written as ones to prove they cannot be set from the bus
		for (k = 0; k < 5; k++) begin
			en = (k == 4) ? 8'hff : 8'($random(seed));
			e = (k == 4) ? 8'hff : 8'($random(seed));
			wr(pedc_pkg::REG_EVENT, {en, 8'hff});
			pulse(e);
			check({15'h0, irq}, {15'h0, ~|(en & e)});
			rd(5'h01, pedc_pkg::REG_EVENT, {en, e});
			rd(5'h01, pedc_pkg::REG_EVENT, {en, 8'h00});
			check({15'h0, irq}, 16'h0001);
		end
		wr(pedc_pkg::REG_CTRL2, 16'h0200);
		check({15'h0, irq}, 16'h0000);
		pulse(8'h01);
		check({15'h0, irq}, 16'h0001);
		rd(5'h01, pedc_pkg::REG_EVENT, 16'hff01);
		rd(5'h01, pedc_pkg::REG_CTRL2, 16'h0200);
		check({15'h0, irq}, 16'h0000);
		// An event that arrives while the enable is low is lost
		ce <= 1'b0;
		pulse(8'h80);
		ce <= 1'b1;
		check({15'h0, irq}, 16'h0000);
		rd(5'h01, pedc_pkg::REG_EVENT, 16'hff00);
		$display("test events done");
		pr = 2'h0;
		pc = 9'h000;
		for (k = 0; k < 4; k++) begin
			cnt = 9'($random(seed));
			wr(pedc_pkg::REG_CABLE, 16'h8000);
			check({15'h0, run}, 16'h0001);
			wr(pedc_pkg::REG_CABLE, 16'h0000);
			rd(5'h01, pedc_pkg::REG_CABLE, {1'b1, pr, 4'h0, pc});
			@(posedge i_clk);
			cab <= {1'b1, k[1:0], cnt};
			@(posedge i_clk);
			cab <= '0;
			repeat (2) @(posedge i_clk);
			check({15'h0, run}, 16'h0000);
			rd(5'h01, pedc_pkg::REG_CABLE, {1'b0, k[1:0], 4'h0, cnt});
			pr = k[1:0];
			pc = cnt;
		end
		$display("test cable done");
		for (k = 0; k < 4; k++) begin
			ln = 3'($random(seed));
			lin <= ln;
			wr(pedc_pkg::REG_CTRL1, {k[1:0], 6'h3f, ~k[0], 7'h7f});
			check({14'h0, led}, {14'h0, k[1:0]});
			check({15'h0, loop}, {15'h0, ~k[0]});
			rd(5'h01, pedc_pkg::REG_CTRL1, {k[1:0], ln, 3'h0, ~k[0], 7'h00});
		end
		$display("test control done");
		u_host.slow = 3;
		rd(5'h02, pedc_pkg::REG_CTRL1, 16'hffff);
		rd(5'h01, 5'h1c, 16'h0000);
		u_host.frame(pedc_pkg::OP_WRITE, 5'h02, pedc_pkg::REG_CTRL1, 16'h0000);
		check({14'h0, led}, 16'h0003);
		$display("test refusals done");
		repeat (4) @(posedge i_clk);
		if (exp_q.size() != 0) check(16'h0000, 16'hffff);
		results();
	end
endmodule
